// *** hw/dbg_port_select.sv ***
// Top: debug port selection, key acquisition, lockout and register slave
`default_nettype none
module dbg_port_select
	import dbg_port_pkg::*;
#(
	parameter int          WINDOW_CYC = KEY_WINDOW_CYC,
	parameter logic [31:0] KEY        = KEY_DEFAULT
)
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Avalon-MM slave
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// Security latch result, sampled at reset release
	input  wire logic        lockout_in,
	// Scan port pins (mode-select, clock, data in, reset)
	input  wire logic        scan_ms_in,
	input  wire logic        scan_clk_in,
	input  wire logic        scan_di_in,
	input  wire logic        scan_rst_n_in,
	output logic             scan_ms_out,
	output logic             scan_ms_oe,
	// USB pin pair (D+ clock, D- data)
	input  wire logic        usb_dp_in,
	input  wire logic        usb_dm_in,
	output logic             usb_dm_out,
	output logic             usb_dm_oe,
	// Data out of the debug core for the serial port
	input  wire logic        ser_do,
	input  wire logic        ser_do_oe,
	// Trace source from the trace unit
	input  wire logic        trace_valid,
	input  wire logic [3:0]  trace_data,
	// Trace outputs
	output logic             single_wire_trace_out,
	output logic [3:0]       parallel_trace_out,
	// Port enables towards pins and core
	output logic             scan_en,
	output logic             scan_chain_en,
	output logic             ser_scan_pair_en,
	output logic             ser_usb_pair_en,
	output logic             scan_pins_gpio,
	output logic             usb_pins_gpio
);
	// -----------------------------------------------------------------
	// Pin synchronisers
	// -----------------------------------------------------------------
	logic [5:0] pins_s; // Synchronised pin levels
	dbg_port_sync #(.W(6)) u_sync
	(
		.clk    (clk),
		.arst_n (arst_n),
		.d      ({scan_ms_in, scan_clk_in, scan_di_in, scan_rst_n_in,
			usb_dp_in, usb_dm_in}),
		.q      (pins_s)
	);

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	logic [15:0] win_cnt_reg;   // Key window down-counter
	logic [15:0] win_cnt_next;
	logic        lock_reg;      // Lockout captured after reset
	logic        lock_next;
	logic        lock_seen_reg; // Latch sampled once
	logic        lock_seen_next;
	pair_sel_t   pair_reg;      // Pair owning the serial port
	pair_sel_t   pair_next;
	logic [4:0]  ctrl_reg;      // Control bits
	logic [4:0]  ctrl_next;
	logic        fw_lock_reg;   // Trace left disabled by firmware
	logic        fw_lock_next;
	logic        sclk_q_reg;    // Previous scan clock level
	logic        uclk_q_reg;    // Previous usb clock level
	logic [31:0] rd_reg;        // Read data
	logic [31:0] rd_next;
	logic        wait_reg;      // Waitrequest
	logic        wait_next;
	logic [9:0]  pins_o_reg;    // Registered pin/port outputs
	logic [9:0]  pins_o_next;
	logic [4:0]  trc_reg;       // Registered trace outputs
	logic [4:0]  trc_next;

	// Key window: counter not spent and part not locked
	wire logic window_open = (win_cnt_reg != 16'h0000) && !lock_reg;
	// Host clock rising edges, seen after the synchroniser
	wire logic scan_rise   = pins_s[4] && !sclk_q_reg;
	wire logic usb_rise    = pins_s[1] && !uclk_q_reg;

	// -----------------------------------------------------------------
	// Key detectors, one per pair
	// -----------------------------------------------------------------
	key_bus_if kb_scan ();
	key_bus_if kb_usb ();
	assign kb_scan.clk_rise = scan_rise;
	assign kb_scan.data_in  = pins_s[5];
	assign kb_scan.window   = window_open && (pair_reg == PAIR_NONE);
	assign kb_usb.clk_rise  = usb_rise;
	assign kb_usb.data_in   = pins_s[0];
	assign kb_usb.window    = window_open && (pair_reg == PAIR_NONE);

	key_detect #(.KEY(KEY)) u_key_scan
	(
		.clk    (clk),
		.arst_n (arst_n),
		.kb     (kb_scan)
	);
	key_detect #(.KEY(KEY)) u_key_usb
	(
		.clk    (clk),
		.arst_n (arst_n),
		.kb     (kb_usb)
	);

	// -----------------------------------------------------------------
	// Accepted write to one register address
	// -----------------------------------------------------------------
	function automatic logic wr_hit(input logic wr, input logic busy,
		input logic [3:0] a, input logic [3:0] target);
		// A write counts only in the cycle where waitrequest is low
		return wr && !busy && (a == target);
	endfunction

	// -----------------------------------------------------------------
	// Next state of acquisition, lockout and control
	// -----------------------------------------------------------------
	always_comb
	begin
		win_cnt_next   = win_cnt_reg;
		lock_next      = lock_reg;
		lock_seen_next = 1'b1;
		pair_next      = pair_reg;
		ctrl_next      = ctrl_reg;
		fw_lock_next   = fw_lock_reg;
		if (!lock_seen_reg)
			lock_next = lockout_in;
		if (win_cnt_reg != 16'h0000)
			win_cnt_next = win_cnt_reg - 16'h0001;
		// a disabled serial port drops its pair
		if (ctrl_reg[CTRL_SER_DIS])
			pair_next = PAIR_NONE;
		// one pair only, scan pair wins a tie
		if (pair_reg == PAIR_NONE && kb_scan.match)
			pair_next = PAIR_SCAN;
		else if (pair_reg == PAIR_NONE && kb_usb.match)
			pair_next = PAIR_USB;
		// Register writes
		if (wr_hit(write, wait_reg, address, ADDR_CTRL))
		begin
			// once refused, stays off until reset
			if (!fw_lock_reg)
			begin
				ctrl_next[CTRL_TRACE_EN]  = writedata[CTRL_TRACE_EN];
				ctrl_next[CTRL_WIRE_EN]   = writedata[CTRL_WIRE_EN];
				ctrl_next[CTRL_PTRACE_EN] = writedata[CTRL_PTRACE_EN];
				fw_lock_next = !writedata[CTRL_TRACE_EN];
			end
			ctrl_next[CTRL_SCAN_DIS] = writedata[CTRL_SCAN_DIS];
			ctrl_next[CTRL_SER_DIS]  = writedata[CTRL_SER_DIS];
		end
		// scan port may enable serial on scan pair
		if (wr_hit(write, wait_reg, address, ADDR_KEY)
			&& writedata == KEY && pair_reg == PAIR_NONE)
			pair_next = PAIR_SCAN;
		if (pair_reg != PAIR_NONE && !ctrl_reg[CTRL_SER_DIS]
			&& wr_hit(write, wait_reg, address, ADDR_CTRL)
			&& !writedata[CTRL_SCAN_DIS])
			ctrl_next[CTRL_SCAN_DIS] = 1'b0;
		// a fresh key match wins over a serial disable
		if (pair_reg == PAIR_NONE && (kb_scan.match || kb_usb.match))
			ctrl_next[CTRL_SER_DIS] = 1'b0;
	end

	// -----------------------------------------------------------------
	// Next bus answer: one wait cycle, then data
	// -----------------------------------------------------------------
	always_comb
	begin
		rd_next   = rd_reg;
		wait_next = 1'b1;
		if ((read || write) && wait_reg)
			wait_next = 1'b0;
		// Read data captured as waitrequest drops
		if (read && wait_reg)
		begin
			case (address)
				ADDR_CTRL:   rd_next = {27'h0, ctrl_reg};
				ADDR_STATUS: rd_next = {26'h0, window_open, lock_reg,
					fw_lock_reg, pair_reg};
				default:     rd_next = ZERO_WORD;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Next pin controls and trace outputs
	// -----------------------------------------------------------------
	always_comb
	begin
		logic scan_on;
		logic ser_s;
		logic ser_u;
		logic trc_on;
		// scan port on its four or five pins
		scan_on = !lock_reg && !ctrl_reg[CTRL_SCAN_DIS] && pins_s[2];
		// serial port on the chosen pair
		ser_s   = !lock_reg && pair_reg == PAIR_SCAN;
		ser_u   = !lock_reg && pair_reg == PAIR_USB;
		trc_on  = !lock_reg && ctrl_reg[CTRL_TRACE_EN];
		pins_o_next = '0;
		pins_o_next[0] = scan_on && !ser_s;
		// chains only via the scan port
		pins_o_next[1] = scan_on && !ser_s;
		pins_o_next[2] = ser_s;
		pins_o_next[3] = ser_u;
		pins_o_next[4] = !(scan_on || ser_s);
		pins_o_next[5] = !ser_u;
		// data pin driven only when core asks
		pins_o_next[6] = ser_do;
		pins_o_next[7] = ser_s && ser_do_oe;
		pins_o_next[8] = ser_do;
		pins_o_next[9] = ser_u && ser_do_oe;
		// both trace ports from one source
		trc_next = {ctrl_reg[CTRL_WIRE_EN] && trc_on && trace_valid
			&& trace_data[0],
			(ctrl_reg[CTRL_PTRACE_EN] && trc_on && trace_valid)
			? trace_data : 4'h0};
	end

	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			win_cnt_reg   <= 16'(WINDOW_CYC);
			lock_reg      <= 1'b1;
			lock_seen_reg <= 1'b0;
			pair_reg      <= PAIR_NONE;
			ctrl_reg      <= 5'h00;
			fw_lock_reg   <= 1'b0;
			sclk_q_reg    <= 1'b0;
			uclk_q_reg    <= 1'b0;
			rd_reg        <= ZERO_WORD;
			wait_reg      <= 1'b1;
			pins_o_reg    <= 10'h030;
			trc_reg       <= 5'h00;
		end
		else
		begin
			win_cnt_reg   <= win_cnt_next;
			lock_reg      <= lock_next;
			lock_seen_reg <= lock_seen_next;
			pair_reg      <= pair_next;
			ctrl_reg      <= ctrl_next;
			fw_lock_reg   <= fw_lock_next;
			sclk_q_reg    <= pins_s[4];
			uclk_q_reg    <= pins_s[1];
			rd_reg        <= rd_next;
			wait_reg      <= wait_next;
			pins_o_reg    <= pins_o_next;
			trc_reg       <= trc_next;
		end
	end

	// Pin bits: 0-1 scan, 2-3 pairs, 4-5 gpio, 6-9 data pin drive
	// Outputs straight from flip-flops
	assign readdata              = rd_reg;
	assign waitrequest           = wait_reg;
	assign scan_en               = pins_o_reg[0];
	assign scan_chain_en         = pins_o_reg[1];
	assign ser_scan_pair_en      = pins_o_reg[2];
	assign ser_usb_pair_en       = pins_o_reg[3];
	assign scan_pins_gpio        = pins_o_reg[4];
	assign usb_pins_gpio         = pins_o_reg[5];
	assign scan_ms_out           = pins_o_reg[6];
	assign scan_ms_oe            = pins_o_reg[7];
	assign usb_dm_out            = pins_o_reg[8];
	assign usb_dm_oe             = pins_o_reg[9];
	assign single_wire_trace_out = trc_reg[4];
	assign parallel_trace_out    = trc_reg[3:0];
endmodule
`default_nettype wire

// *** hw/dbg_port_pkg.sv ***
// Package of constants and types for the debug port select and acquire block
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
`default_nettype none
package dbg_port_pkg;
	// Clock and timing
	localparam int          CLK_MHZ        = 250;
	localparam int          KEY_WINDOW_NS  = 8000;
	localparam int          KEY_WINDOW_CYC = KEY_WINDOW_NS * CLK_MHZ / 1000;
	// Register map (byte addresses)
	localparam logic [3:0]  ADDR_CTRL      = 4'h0;
	localparam logic [3:0]  ADDR_STATUS    = 4'h4;
	localparam logic [3:0]  ADDR_KEY       = 4'h8;
	// Control field positions
	localparam int          CTRL_TRACE_EN  = 0;
	localparam int          CTRL_WIRE_EN   = 1;
	localparam int          CTRL_PTRACE_EN = 2;
	localparam int          CTRL_SCAN_DIS  = 3;
	localparam int          CTRL_SER_DIS   = 4;
	// Default key value, arbitrary
	localparam logic [31:0] KEY_DEFAULT    = 32'h5A3C_96E1;
	localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
	// Which pair holds the serial debug port
	typedef enum logic [2:0]
	{
		PAIR_NONE = 3'b001,
		PAIR_SCAN = 3'b010,
		PAIR_USB  = 3'b100
	} pair_sel_t;
endpackage
`default_nettype wire

// *** hw/key_bus_if.sv ***
// Interface carrying key-detector inputs and result between modules
`default_nettype none
interface key_bus_if;
	logic clk_rise; // Edge of the host's data clock
	logic data_in;  // Sampled data bit
	logic window;   // Key window still open
	logic match;    // Key seen, one-cycle pulse
	modport det (input clk_rise, data_in, window, output match);
	modport ctl (output clk_rise, data_in, window, input match);
endinterface
`default_nettype wire

// *** hw/key_detect.sv ***
// Shift register that spots the acquisition key on one pin pair
`default_nettype none
module key_detect
	import dbg_port_pkg::*;
#(
	parameter logic [31:0] KEY = KEY_DEFAULT
)
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// Detector link
	key_bus_if.det    kb
);
	logic [31:0] shift_reg;  // Recent bits
	logic [31:0] shift_next;
	logic        hit_reg;    // Match pulse
	logic        hit_next;

	// -----------------------------------------------------------------
	// Next value of the shifter
	// -----------------------------------------------------------------
	always_comb
	begin
		shift_next = shift_reg;
		hit_next   = 1'b0;
		if (kb.clk_rise && kb.window)
		begin
			shift_next = {shift_reg[30:0], kb.data_in};
			hit_next   = ({shift_reg[30:0], kb.data_in} == KEY);
		end
	end

	// Registers
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			shift_reg <= ZERO_WORD;
			hit_reg   <= 1'b0;
		end
		else
		begin
			shift_reg <= shift_next;
			hit_reg   <= hit_next;
		end
	end

	assign kb.match = hit_reg;
endmodule
`default_nettype wire

// *** hw/dbg_port_sync.sv ***
// Two-flop synchroniser for a group of pin inputs
`default_nettype none
module dbg_port_sync
#(
	parameter int W = 4
)
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         arst_n,
	// Raw and synchronised pins
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_reg; // First stage, read only by second
	logic [W-1:0] s2_reg; // Second stage

	// Two stages in series
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
		end
		else
		begin
			s1_reg <= d;
			s2_reg <= s1_reg;
		end
	end

	assign q = s2_reg;
endmodule
`default_nettype wire

// *** testbench/dbg_port_props.sv ***
// Assertion checker for the debug port select and acquire block
`default_nettype none
module dbg_port_props
#(
	parameter int WINDOW_CYC = 2000
)
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        arst_n,
	// Register bus
	input wire logic [3:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	// Pins and trace
	input wire logic        lockout_in,
	input wire logic        scan_rst_n_in,
	input wire logic [3:0]  trace_data,
	input wire logic        single_wire_trace_out,
	input wire logic [3:0]  parallel_trace_out,
	// Port enables
	input wire logic        scan_en,
	input wire logic        scan_chain_en,
	input wire logic        ser_scan_pair_en,
	input wire logic        ser_usb_pair_en,
	input wire logic        scan_pins_gpio,
	input wire logic        usb_pins_gpio
);
	timeunit 1ns;
	timeprecision 100ps;
	// Cycles since reset release, saturating
	logic [15:0] age_reg;
	logic [15:0] age_next;
	// Next age value
	always_comb
	begin
		age_next = age_reg;
		if (age_reg != 16'hFFFF)
			age_next = age_reg + 16'h0001;
	end
	// Age register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			age_reg <= 16'h0000;
		else
			age_reg <= age_next;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_wait_one_cycle: assert property ((read || write) && waitrequest
		|=> !waitrequest) else $error("bus answer late");
	a_wait_stands_one: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low too long");
	a_unmapped_zero: assert property (read && !waitrequest &&
		!(address inside {4'h0, 4'h4, 4'h8}) |-> readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_lock_gates_all: assert property (lockout_in && $past(lockout_in)
		|-> !(scan_en || ser_scan_pair_en || ser_usb_pair_en)
		&& parallel_trace_out == 4'h0) else $error("port open while locked");
	a_one_pair_only: assert property (!(ser_scan_pair_en && ser_usb_pair_en))
		else $error("both pairs enabled");
	a_usb_gpio_swap: assert property (ser_usb_pair_en != usb_pins_gpio)
		else $error("usb pair function mismatch");
	a_scan_not_gpio: assert property (scan_en |-> !scan_pins_gpio)
		else $error("scan pins left as gpio");
	a_chain_scan_only: assert property (scan_chain_en |-> scan_en)
		else $error("chain without scan port");
	a_window_closed: assert property (age_reg > WINDOW_CYC + 8
		|-> !$rose(ser_usb_pair_en)) else $error("late key accepted");
	a_trace_lag_one: assert property (parallel_trace_out == 4'h0 ||
		parallel_trace_out == $past(trace_data)) else $error("trace data");
	a_scan_rst_off: assert property (!scan_rst_n_in [*5] |-> !scan_en)
		else $error("scan on during test reset");
endmodule
bind dbg_port_select dbg_port_props #(.WINDOW_CYC(WINDOW_CYC)) props_u
(
	.clk, .arst_n, .address, .read, .write, .readdata, .waitrequest,
	.lockout_in, .scan_rst_n_in, .trace_data, .single_wire_trace_out,
	.parallel_trace_out, .scan_en, .scan_chain_en, .ser_scan_pair_en,
	.ser_usb_pair_en, .scan_pins_gpio, .usb_pins_gpio
);
`default_nettype wire

// *** testbench/dbg_host_probe.sv ***
// Behavioural debug host that shifts the acquisition key into a pin pair
`default_nettype none
module dbg_host_probe
(
	// Scan pair: clock and mode-select data
	output logic scan_clk,
	output logic scan_ms,
	// Usb pair: D+ clock and D- data
	output logic usb_dp,
	output logic usb_dm
);
	timeunit 1ns;
	timeprecision 100ps;
	// Clocks stand still low outside frames
	initial
	begin
		scan_clk = 1'b0;
		scan_ms = 1'b0;
		usb_dp = 1'b0;
		usb_dm = 1'b0;
	end
	// host sends key frames only, no scan traffic
	// host clocks one pin, MSB first, 64 ns period
	task automatic send_key(input logic [31:0] word, input logic usb);
		int i;
		#7;
		for (i = 31; i >= 0; i--)
		begin
			if (usb) usb_dm = word[i]; else scan_ms = word[i];
			#32;
			if (usb) usb_dp = 1'b1; else scan_clk = 1'b1;
			#32;
			if (usb) usb_dp = 1'b0; else scan_clk = 1'b0;
		end
		// Released data line shows the inverse of the last bit
		if (usb) usb_dm = ~word[0]; else scan_ms = ~word[0];
	endtask
endmodule
`default_nettype wire

// *** testbench/tb_dbg_port_select.sv ***
// Self-checking bench for the debug port select and acquire block
`default_nettype none
`define CHK(got, exp, msg) \
	begin \
		n_tests++; \
		if ((got) !== (exp)) \
		begin \
			err_count++; \
			$display("wrong value at %0t: %s", $time, msg); \
		end \
	end
module tb_dbg_port_select;
	timeunit 1ns;
	timeprecision 100ps;
	import dbg_port_pkg::*;
	localparam int WIN = 600;
	logic        clk, arst_n, read, write, waitrequest, lockout_in;
	logic        scan_ms_in, scan_clk_in, scan_rst_n_in, usb_dp_in, usb_dm_in;
	logic        trace_valid, single_wire_trace_out, scan_en, scan_chain_en;
	logic        ser_scan_pair_en, ser_usb_pair_en;
	logic        scan_pins_gpio, usb_pins_gpio;
	logic        ser_do, ser_do_oe, scan_ms_out, scan_ms_oe;
	logic        usb_dm_out, usb_dm_oe;
	logic [3:0]  address, trace_data, parallel_trace_out;
	logic [31:0] writedata, readdata, rd;
	int          err_count, n_tests;
	// Device under test
	dbg_port_select #(.WINDOW_CYC(WIN)) dut_u
	(
		.clk, .arst_n, .address, .read, .write, .writedata, .readdata,
		.waitrequest, .lockout_in, .scan_ms_in, .scan_clk_in,
		.scan_di_in(1'b0), .scan_rst_n_in, .scan_ms_out, .scan_ms_oe,
		.usb_dp_in, .usb_dm_in, .usb_dm_out, .usb_dm_oe,
		.ser_do, .ser_do_oe, .trace_valid, .trace_data,
		.single_wire_trace_out, .parallel_trace_out, .scan_en,
		.scan_chain_en, .ser_scan_pair_en, .ser_usb_pair_en,
		.scan_pins_gpio, .usb_pins_gpio
	);
	// Debug host on both pin pairs
	dbg_host_probe probe_u
	(
		.scan_clk(scan_clk_in), .scan_ms(scan_ms_in),
		.usb_dp(usb_dp_in), .usb_dm(usb_dm_in)
	);
	// Verdict and end of run
	task automatic report_and_stop;
		if (err_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// One bus cycle; held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		read <= ~wr;
		write <= wr;
		writedata <= d;
		// Waitrequest and read data are taken at rising edges only
		do
		begin
			@(posedge clk);
			n++;
		end
		while (waitrequest !== 1'b0 && n < 20);
		if (waitrequest !== 1'b0)
		begin
			err_count++;
			report_and_stop();
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	// Reset for five cycles with the given lock state
	task automatic do_reset(input logic lk);
		arst_n <= 1'b0;
		lockout_in <= lk;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
	endtask
	// Key shift then settle time for the enable
	task automatic key(input logic [31:0] w, input logic usb);
		probe_u.send_key(w, usb);
		repeat (20) @(posedge clk);
	endtask
	// Clock, 4 ns period
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Hang guard
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		report_and_stop();
	end
	// Main sequence
	initial
	begin
		{arst_n, read, write, lockout_in, address, writedata} = '0;
		{scan_rst_n_in, trace_valid, trace_data} = 6'h35;
		{ser_do, ser_do_oe} = 2'h0;
		{err_count, n_tests} = '0;
		// Usb pair acquisition, registers, trace, scan control
		do_reset(1'b0);
		key(KEY_DEFAULT, 1'b1);
		`CHK(scan_en, 1'b1, "scan default")
		`CHK(parallel_trace_out, 4'h0, "trace off at reset")
		`CHK(ser_usb_pair_en, 1'b1, "usb acquire")
		`CHK(usb_pins_gpio, 1'b0, "usb pins to debug")
		ser_do <= 1'b1;
		ser_do_oe <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK(usb_dm_oe, 1'b1, "usb data pin driven")
		`CHK(usb_dm_out, 1'b1, "usb data pin level")
		`CHK(scan_ms_oe, 1'b0, "scan data pin idle")
		ser_do_oe <= 1'b0;
		bus(1'b0, ADDR_STATUS, 32'h0000_0000, rd);
		`CHK(rd[2:0], PAIR_USB, "pair status")
		bus(1'b0, 4'hC, 32'h0000_0000, rd);
		`CHK(rd, 32'h0000_0000, "unmapped read")
		bus(1'b1, ADDR_CTRL, 32'h0000_0007, rd);
		repeat (3) @(posedge clk);
		`CHK(parallel_trace_out, 4'h5, "parallel trace")
		`CHK(single_wire_trace_out, 1'b1, "single wire trace")
		trace_data <= 4'hA;
		repeat (2) @(posedge clk);
		`CHK(parallel_trace_out, 4'hA, "parallel trace follows")
		`CHK(single_wire_trace_out, 1'b0, "single wire follows")
		scan_rst_n_in <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK(scan_en, 1'b0, "scan held by test reset")
		scan_rst_n_in <= 1'b1;
		bus(1'b1, ADDR_CTRL, 32'h0000_0008, rd);
		repeat (4) @(posedge clk);
		`CHK(scan_pins_gpio, 1'b1, "scan disabled to gpio")
		bus(1'b1, ADDR_CTRL, 32'h0000_0007, rd);
		repeat (4) @(posedge clk);
		`CHK(scan_en, 1'b1, "scan re-enabled")
		`CHK(parallel_trace_out, 4'h0, "trace stays off")
		bus(1'b1, ADDR_CTRL, 32'h0000_0010, rd);
		repeat (4) @(posedge clk);
		`CHK(usb_pins_gpio, 1'b1, "serial disabled to gpio")
		// Wrong key, then serial enabled from the register
		do_reset(1'b0);
		key(~KEY_DEFAULT, 1'b0);
		`CHK(ser_scan_pair_en, 1'b0, "wrong key")
		bus(1'b1, ADDR_KEY, KEY_DEFAULT, rd);
		repeat (4) @(posedge clk);
		`CHK(ser_scan_pair_en, 1'b1, "enable from scan")
		// Scan pair acquisition, serial disabled before the key
		do_reset(1'b0);
		bus(1'b1, ADDR_CTRL, 32'h0000_0010, rd);
		key(KEY_DEFAULT, 1'b0);
		`CHK(ser_scan_pair_en, 1'b1, "scan pair acquire")
		`CHK(ser_usb_pair_en, 1'b0, "other pair idle")
		ser_do_oe <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK(scan_ms_oe, 1'b1, "scan data pin driven")
		`CHK(scan_ms_out, 1'b1, "scan data pin level")
		`CHK(usb_dm_oe, 1'b0, "usb data pin idle")
		ser_do_oe <= 1'b0;
		// Key after the window
		do_reset(1'b0);
		repeat (WIN + 20) @(posedge clk);
		key(KEY_DEFAULT, 1'b1);
		`CHK(ser_usb_pair_en, 1'b0, "late key")
		// Security lockout
		do_reset(1'b1);
		key(KEY_DEFAULT, 1'b1);
		`CHK(ser_usb_pair_en, 1'b0, "locked key")
		`CHK(scan_en, 1'b0, "locked scan")
		bus(1'b0, ADDR_STATUS, 32'h0000_0000, rd);
		`CHK(rd[4], 1'b1, "lock status")
		report_and_stop();
	end
endmodule
`default_nettype wire
